// >>> include/mdpsc_params.svh
`ifndef MDPSC_PARAMS_SVH
`define MDPSC_PARAMS_SVH

// System clock period
`define MDPSC_CLK_PERIOD_NS 4
// Status release time-out after a frame error, automatic restart only
`define MDPSC_RESTART_TIMEOUT_NS 30000
// Cycles of the time-out, rounded down
`define MDPSC_RESTART_CYCLES (`MDPSC_RESTART_TIMEOUT_NS / `MDPSC_CLK_PERIOD_NS)
// Bits this device loads before it hands the chain on
`define MDPSC_LOAD_BITS 64
// First byte of a valid frame
`define MDPSC_SYNC_BYTE 8'hA5
// Bits per configuration byte
`define MDPSC_BYTE_BITS 8
// Synchroniser depth
`define MDPSC_SYNC_STAGES 2

`endif

// >>> include/mdpsc_pkg.sv
package mdpsc_pkg;

	// Main sequencer states
	typedef enum logic [2:0] {
		MDPSC_ST_RESET = 3'b000,
		MDPSC_ST_LOAD  = 3'b001,
		MDPSC_ST_WAIT  = 3'b010,
		MDPSC_ST_USER  = 3'b011,
		MDPSC_ST_ERROR = 3'b100
	} mdpsc_state_type;

	// Pin levels sensed from the chain, all asynchronous to the system clock
	typedef struct packed {
		logic cfg_req_n;
		logic ser_clk;
		logic ser_data;
		logic ce_n;
		logic status_n;
		logic done;
	} mdpsc_pins_type;

	// Received configuration byte
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} mdpsc_byte_type;

endpackage

// >>> src/mdpsc_sync.sv
`timescale 1ns/1ns
`include "mdpsc_params.svh"

// Two-stage synchroniser for a vector of independent levels
module mdpsc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,     // System clock
	input  wire logic             rst_b,   // Async reset, active low
	input  wire logic [WIDTH-1:0] async_d, // Asynchronous levels
	output logic      [WIDTH-1:0] sync_q   // Synchronised levels
);

	logic [WIDTH-1:0] meta_ff;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= '0;
			sync_q  <= '0;
		end else begin
			meta_ff <= async_d;
			sync_q  <= meta_ff;
		end
	end

	// Width check
	initial begin
		if (WIDTH < 1) begin
			$error("mdpsc_sync: WIDTH must be at least 1");
		end
	end

endmodule

// >>> src/mdpsc_target.sv
`timescale 1ns/1ns
`include "mdpsc_params.svh"

module mdpsc_target
	import mdpsc_pkg::*;
#(
	parameter int LOAD_BITS      = `MDPSC_LOAD_BITS,
	parameter int RESTART_CYCLES = `MDPSC_RESTART_CYCLES
) (
	input  wire logic       CLK_SYS,                   // System clock, 250 MHz
	input  wire logic       RST_B,                     // Async reset, active low
	input  wire logic       CONFIG_REQUEST_N,          // Configuration request pin
	input  wire logic       SERIAL_CFG_CLOCK,          // Serial configuration clock pin
	input  wire logic       SERIAL_CFG_DATA,           // Serial configuration data pin
	input  wire logic       CHAIN_ENABLE_IN_N,         // Chip enable from previous device
	input  wire logic       AUTO_RESTART,              // Automatic restart on frame error
	input  wire logic       SHARED_ERROR_STATUS_N_IN,  // Status line level
	output logic            SHARED_ERROR_STATUS_N_OUT, // Status drive value, always low
	output logic            SHARED_ERROR_STATUS_N_OE,  // Status pulled low when high
	input  wire logic       SHARED_LOAD_DONE_IN,       // Done line level
	output logic            SHARED_LOAD_DONE_OUT,      // Done drive value, always low
	output logic            SHARED_LOAD_DONE_OE,       // Done pulled low when high
	output logic            CHAIN_ENABLE_OUT_N,        // Chip enable to next device
	output logic            USER_MODE,                 // Device in user mode
	output logic            FRAME_ERROR,               // Device holds an error
	output logic [7:0]      CFG_BYTE,                  // Last assembled byte
	output logic            CFG_BYTE_VALID             // One-cycle pulse per byte
);

	localparam int CNT_W = $clog2(LOAD_BITS + 1);

	mdpsc_state_type  state_ff;
	mdpsc_state_type  nxt_state;
	mdpsc_pins_type   pins_async;
	mdpsc_pins_type   pins_sync;
	mdpsc_byte_type   byte_ff;
	mdpsc_byte_type   nxt_byte;
	logic             ser_clk_prev_ff;
	logic [CNT_W-1:0] bit_cnt_ff;
	logic [CNT_W-1:0] nxt_bit_cnt;
	logic [7:0]       shift_ff;
	logic [7:0]       nxt_shift;
	logic [15:0]      timer_ff;
	logic [15:0]      nxt_timer;
	logic             status_oe_ff;
	logic             done_oe_ff;
	logic             chain_out_n_ff;
	logic             user_ff;
	logic             error_ff;

	// Elaboration checks
	initial begin
		if (LOAD_BITS < 16 || (LOAD_BITS % `MDPSC_BYTE_BITS) != 0) begin
			$error("mdpsc_target: LOAD_BITS must be a multiple of 8, at least 16");
		end
		if (RESTART_CYCLES < 1 || RESTART_CYCLES > 65535) begin
			$error("mdpsc_target: RESTART_CYCLES out of range 1..65535");
		end
	end

	// All pins cross from outside the system clock domain
	assign pins_async = '{cfg_req_n: CONFIG_REQUEST_N, ser_clk: SERIAL_CFG_CLOCK,
		ser_data: SERIAL_CFG_DATA, ce_n: CHAIN_ENABLE_IN_N,
		status_n: SHARED_ERROR_STATUS_N_IN, done: SHARED_LOAD_DONE_IN};

	mdpsc_sync #(
		.WIDTH($bits(mdpsc_pins_type))
	) u_pin_sync (
		.clk     (CLK_SYS),
		.rst_b   (RST_B),
		.async_d (pins_async),
		.sync_q  (pins_sync)
	);

	// Edge of the link clock found by the system clock
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			ser_clk_prev_ff <= 1'b0;
		end else begin
			ser_clk_prev_ff <= pins_sync.ser_clk;
		end
	end

	// Decodes; the line levels are wired-AND of every party on the chain
	wire ser_clk_rise  = pins_sync.ser_clk & ~ser_clk_prev_ff;
	wire chain_enabled = ~pins_sync.ce_n;
	wire line_status_n = pins_sync.status_n;
	wire line_done     = pins_sync.done;
	wire take_bit      = chain_enabled & line_status_n & ser_clk_rise;
	wire [7:0] shifted = {pins_sync.ser_data, shift_ff[7:1]};
	wire [CNT_W-1:0] cnt_inc   = bit_cnt_ff + CNT_W'(1);
	wire byte_full     = (cnt_inc[2:0] == 3'b000);
	wire first_byte    = (cnt_inc == CNT_W'(`MDPSC_BYTE_BITS));
	wire sync_bad      = first_byte & (shifted != `MDPSC_SYNC_BYTE);
	wire load_last     = (cnt_inc == CNT_W'(LOAD_BITS));
	wire timeout_hit   = (timer_ff == 16'(RESTART_CYCLES - 1));
	wire req_low       = ~pins_sync.cfg_req_n;

	// Sequencer next state; a request low overrides every state
	always_comb begin
		nxt_state   = state_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_shift   = shift_ff;
		nxt_timer   = '0;
		nxt_byte    = '{valid: 1'b0, data: byte_ff.data};
		case (state_ff)
			MDPSC_ST_RESET: begin
				nxt_bit_cnt = '0;
				if (!req_low) begin
					nxt_state = MDPSC_ST_LOAD;
				end
			end
			MDPSC_ST_LOAD: begin
				if (!line_status_n) begin
					nxt_bit_cnt = '0;
				end else if (take_bit) begin
					nxt_shift   = shifted;
					nxt_bit_cnt = cnt_inc;
					if (byte_full) begin
						nxt_byte = '{valid: 1'b1, data: shifted};
					end
					if (sync_bad) begin
						nxt_state = MDPSC_ST_ERROR;
					end else if (load_last) begin
						nxt_state = MDPSC_ST_WAIT;
					end
				end
			end
			MDPSC_ST_WAIT: begin
				if (!line_status_n) begin
					nxt_state   = MDPSC_ST_LOAD;
					nxt_bit_cnt = '0;
				end else if (line_done) begin
					nxt_state = MDPSC_ST_USER;
				end
			end
			MDPSC_ST_USER: begin
				nxt_state = MDPSC_ST_USER;
			end
			MDPSC_ST_ERROR: begin
				nxt_bit_cnt = '0;
				if (AUTO_RESTART) begin
					nxt_timer = timer_ff + 16'h0001;
					if (timeout_hit) begin
						nxt_state = MDPSC_ST_LOAD;
					end
				end
			end
			default: begin
				nxt_state = MDPSC_ST_RESET;
			end
		endcase
		if (req_low) begin
			nxt_state   = MDPSC_ST_RESET;
			nxt_bit_cnt = '0;
			nxt_timer   = '0;
		end
	end

	// Pin drives decoded from the next state so outputs track it at once
	wire nxt_status_oe = (nxt_state == MDPSC_ST_RESET) | (nxt_state == MDPSC_ST_ERROR);
	wire nxt_done_oe   = (nxt_state == MDPSC_ST_RESET) | (nxt_state == MDPSC_ST_LOAD)
		| (nxt_state == MDPSC_ST_ERROR);
	wire nxt_chain_n   = ~((nxt_state == MDPSC_ST_WAIT) | (nxt_state == MDPSC_ST_USER));

	// State and data registers
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			state_ff   <= MDPSC_ST_RESET;
			bit_cnt_ff <= '0;
			shift_ff   <= 8'h00;
			timer_ff   <= 16'h0000;
			byte_ff    <= '0;
		end else begin
			state_ff   <= nxt_state;
			bit_cnt_ff <= nxt_bit_cnt;
			shift_ff   <= nxt_shift;
			timer_ff   <= nxt_timer;
			byte_ff    <= nxt_byte;
		end
	end

	// Pin and status registers; reset holds status and done low like power-up
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			status_oe_ff   <= 1'b1;
			done_oe_ff     <= 1'b1;
			chain_out_n_ff <= 1'b1;
			user_ff        <= 1'b0;
			error_ff       <= 1'b0;
		end else begin
			status_oe_ff   <= nxt_status_oe;
			done_oe_ff     <= nxt_done_oe;
			chain_out_n_ff <= nxt_chain_n;
			user_ff        <= (nxt_state == MDPSC_ST_USER);
			error_ff       <= (nxt_state == MDPSC_ST_ERROR);
		end
	end

	// Open-drain: only a low is ever driven
	assign SHARED_ERROR_STATUS_N_OUT = 1'b0;
	assign SHARED_LOAD_DONE_OUT      = 1'b0;
	assign SHARED_ERROR_STATUS_N_OE  = status_oe_ff;
	assign SHARED_LOAD_DONE_OE       = done_oe_ff;
	assign CHAIN_ENABLE_OUT_N        = chain_out_n_ff;
	assign USER_MODE                 = user_ff;
	assign FRAME_ERROR               = error_ff;
	assign CFG_BYTE                  = byte_ff.data;
	assign CFG_BYTE_VALID            = byte_ff.valid;

endmodule

// >>> verification/mdpsc_target_chk.sv
`timescale 1ns/1ns
// Port watch on one target of the chain
module mdpsc_target_chk #(
	parameter int RESTART_CYCLES = 7500
) (
	input wire logic CLK_SYS,                  // Clock
	input wire logic RST_B,                    // Reset
	input wire logic CONFIG_REQUEST_N,         // Request pin
	input wire logic SERIAL_CFG_CLOCK,         // Serial clock
	input wire logic AUTO_RESTART,             // Restart option
	input wire logic SHARED_LOAD_DONE_IN,      // Done line
	input wire logic SHARED_ERROR_STATUS_N_OE, // Status pull
	input wire logic SHARED_LOAD_DONE_OE,      // Done pull
	input wire logic CHAIN_ENABLE_OUT_N,       // Chain out
	input wire logic USER_MODE,                // User mode
	input wire logic FRAME_ERROR,              // Error held
	input wire logic CFG_BYTE_VALID            // Byte pulse
);
	int err_cnt_ff;
	int nxt_err_cnt;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	// Error age, for the release window
	assign nxt_err_cnt = FRAME_ERROR ? err_cnt_ff + 1 : 0;
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) err_cnt_ff <= 0;
		else err_cnt_ff <= nxt_err_cnt;
	end
	AST_CHAIN_DONE: assert property (SHARED_LOAD_DONE_OE == CHAIN_ENABLE_OUT_N)
		else $error("chain enable and done release differ");
	AST_USER_DONE: assert property ($rose(USER_MODE) |-> $past(SHARED_LOAD_DONE_IN, 3))
		else $error("user mode without done line");
	AST_USER_LOADED: assert property (USER_MODE |-> !CHAIN_ENABLE_OUT_N)
		else $error("user mode before hand-off");
	AST_ERR_STATUS: assert property ($rose(FRAME_ERROR) |-> SHARED_ERROR_STATUS_N_OE)
		else $error("error without status pull");
	AST_ERR_HOLD: assert property (FRAME_ERROR && SHARED_ERROR_STATUS_N_OE && !AUTO_RESTART && CONFIG_REQUEST_N
		|=> SHARED_ERROR_STATUS_N_OE) else $error("status released without restart");
	AST_RESTART_BOUND: assert property (FRAME_ERROR && AUTO_RESTART |-> err_cnt_ff <= RESTART_CYCLES + 3)
		else $error("restart time-out overrun");
	AST_RESTART_EARLY: assert property ($fell(FRAME_ERROR) && CONFIG_REQUEST_N && $past(CONFIG_REQUEST_N, 4)
		|-> $past(err_cnt_ff) >= RESTART_CYCLES - 2) else $error("status released too early");
	AST_BYTE_PULSE: assert property (CFG_BYTE_VALID |-> $past(SERIAL_CFG_CLOCK, 3) && !$past(SERIAL_CFG_CLOCK, 4)
		##1 !CFG_BYTE_VALID) else $error("byte pulse off the serial edge");
endmodule

bind mdpsc_target mdpsc_target_chk #(.RESTART_CYCLES(RESTART_CYCLES)) u_chk (.*);

// >>> verification/mdpsc_host_model.sv
`timescale 1ns/1ns
// Host at the far side of the chain: request, clock, data, status
module mdpsc_host_model (
	output logic     cfg_req_n, // Request pin
	output logic     sclk,      // Serial clock, still between frames
	output logic     sdata,     // Serial data
	output logic     st_pull,   // Host pull on status
	input wire logic done_line  // Shared done level
);
	logic memory_cascade_out_n; // First memory hands the stream on when low
	initial begin
		cfg_req_n = 1'h0;
		sclk = 1'h0;
		sdata = 1'h0;
		st_pull = 1'h0;
		memory_cascade_out_n = 1'h1;
	end
	// Low pulse then rising edge starts a load
	task restart;
		cfg_req_n = 1'h0;
		#100 cfg_req_n = 1'h1;
	endtask
	// One byte, low bit first, 80 ns clock
	task send_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			sdata = b[i];
			#40 sclk = 1'h1;
			#40 sclk = 1'h0;
		end
	endtask
	// Two cascaded memories: the second takes over inside one serial clock
	task cascade(input logic [7:0] first_b, input logic [7:0] second_b);
		send_byte(first_b);
		memory_cascade_out_n = 1'h0; // Next memory selected with no gap in the stream
		send_byte(second_b);
		memory_cascade_out_n = 1'h1;
	endtask
	// Extra clocks while waiting for done
	task trail(input int n);
		sdata = 1'h1; // Data over, line held high like its pull-up
		for (int i = 0; i < n && done_line !== 1'h1; i++) begin
			#40 sclk = 1'h1;
			#40 sclk = 1'h0;
		end
	endtask
	// Pulse status low to halt the chain
	task abort;
		st_pull = 1'h1;
		#2000 st_pull = 1'h0;
	endtask
endmodule

// >>> verification/test_multi_device_passive_serial_config_chain.sv
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module test_multi_device_passive_serial_config_chain;
	import mdpsc_pkg::*;
	typedef struct packed {logic [7:0] b; logic err;} mdpsc_row_type;
	mdpsc_row_type rows [4] = '{'{8'hA5, 1'h0}, '{8'h5A, 1'h1}, '{8'h00, 1'h1}, '{8'hA4, 1'h1}};
	logic clk = 1'h0, rst_b = 1'h0, ce_n = 1'h0, auto = 1'h0, hold = 1'h0;
	wire req_n, sclk, sdata, st_pull, st_oe, dn_oe, ceo_n, um, ferr, bv, st_out, dn_out;
	wire [7:0] cb;
	int fail_count = 0, samples_checked = 0, test_no = 0, byte_pulses = 0;
	// Open drain: a pin pulls its line only while enabled, else the pull-up wins
	wire st_line = (st_oe ? st_out : 1'h1) && !st_pull;
	wire dn_line = (dn_oe ? dn_out : 1'h1) && !hold;
	always #2 clk = ~clk;
	// Byte strobes seen, one per assembled byte
	always @(posedge clk) if (bv === 1'h1) byte_pulses++;
	mdpsc_host_model host (.cfg_req_n(req_n), .sclk(sclk), .sdata(sdata), .st_pull(st_pull), .done_line(dn_line));
	mdpsc_target #(.RESTART_CYCLES(20)) dut (.CLK_SYS(clk), .RST_B(rst_b), .CONFIG_REQUEST_N(req_n),
		.SERIAL_CFG_CLOCK(sclk), .SERIAL_CFG_DATA(sdata), .CHAIN_ENABLE_IN_N(ce_n), .AUTO_RESTART(auto),
		.SHARED_ERROR_STATUS_N_IN(st_line), .SHARED_ERROR_STATUS_N_OUT(st_out), .SHARED_ERROR_STATUS_N_OE(st_oe),
		.SHARED_LOAD_DONE_IN(dn_line), .SHARED_LOAD_DONE_OUT(dn_out), .SHARED_LOAD_DONE_OE(dn_oe),
		.CHAIN_ENABLE_OUT_N(ceo_n), .USER_MODE(um), .FRAME_ERROR(ferr), .CFG_BYTE(cb), .CFG_BYTE_VALID(bv));
	// Verdict and end of run
	task end_sim;
		$display("checked=%0d failed=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Restart the chain, bounded wait for status release
	task start;
		host.restart();
		for (int k = 0; k < 100 && st_oe !== 1'h0; k++) @(posedge clk);
		#1 `CHK(st_oe, 1'h0)
	endtask
	task done_test;
		test_no++;
		$display("test %0d done", test_no);
	endtask
	// Watchdog well past the expected run
	initial begin
		#200000 fail_count++;
		end_sim();
	end
	initial begin
		repeat (6) @(posedge clk);
		`CHK({st_oe, dn_oe, ceo_n, um, ferr, st_out, dn_out}, 7'h70)
		done_test();
		#1 rst_b = 1'h1;
		// First-byte table: good frame and bad frames
		foreach (rows[i]) begin
			start();
			host.send_byte(rows[i].b);
			`CHK(cb, rows[i].b)
			`CHK(ferr, rows[i].err)
			`CHK(byte_pulses, i + 1)
			#400 `CHK(st_oe, rows[i].err)
			done_test();
		end
		// Halt mid-load restarts the count from the first bit
		start();
		host.send_byte(8'hA5);
		host.abort();
		#1000 for (int i = 0; i < 5; i++) host.send_byte(i ? 8'(i) : 8'hA5);
		host.cascade(8'h05, 8'h06);
		`CHK({ceo_n, dn_oe, ferr}, 3'h6)
		hold = 1'h1; // Another party still holds done
		host.send_byte(8'hFF);
		`CHK({ceo_n, dn_oe}, 2'h0)
		done_test();
		// Done still held elsewhere: no user mode
		host.trail(16);
		`CHK(um, 1'h0)
		hold = 1'h0;
		host.trail(64);
		#40 `CHK(um, 1'h1)
		done_test();
		// Automatic restart releases status after the time-out
		auto = 1'h1;
		start();
		host.send_byte(8'h00);
		#1 `CHK(st_oe, 1'h1)
		#200 `CHK(st_oe, 1'h0)
		done_test();
		// Chain enable high: bits are ignored, then taken again once low
		ce_n = 1'h1;
		host.send_byte(8'h3C);
		`CHK({cb, ferr}, 9'h000)
		ce_n = 1'h0;
		host.send_byte(8'hA5);
		`CHK({cb, ferr}, 9'h14A)
		done_test();
		// Reset in mid-load: levels return at once, then a request reloads
		rst_b = 1'h0;
		#8 `CHK({st_oe, dn_oe, ceo_n, um, ferr, cb}, 13'h1C00)
		rst_b = 1'h1;
		start();
		done_test();
		end_sim();
	end
endmodule
